// *** standby_pkg.sv ***
// Constants and types shared by the standby clock controller
package standby_pkg;
  localparam logic [15:0] OSC_SETTLE_SELECT_ADDR = 16'hfff4;
  localparam int SETTLE_SEL_LO_POS = 0;
  localparam int SETTLE_SEL_HI_POS = 1;
  localparam int SLOW_OSC_HALT_POS = 0;
  localparam int CLK_MHZ = 100;
  // Operation stop interval after deep-stop release, in ns (typical)
  localparam int STOP_HOLD_NS = 34000;
  localparam int STOP_HOLD_CYC = (STOP_HOLD_NS * CLK_MHZ) / 1000;
  localparam int SETTLE_EXP_0 = 10;
  localparam int SETTLE_EXP_1 = 12;
  localparam int SETTLE_EXP_2 = 15;
  localparam int SETTLE_EXP_3 = 17;
  // Idle resume delays in clocks
  localparam int IDLE_RESUME_VEC = 12;
  localparam int IDLE_RESUME_NOVEC = 4;
  localparam int CNT_W = 18;
  localparam logic [1:0] SETTLE_SEL_RST = 2'h0;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_IDLE = 3'b001,
    ST_STOP = 3'b011,
    ST_OSCWAIT = 3'b010,
    ST_SETTLE = 3'b110,
    ST_HOLD = 3'b111,
    ST_RESUME = 3'b101
  } sb_state_t;
endpackage

// *** wake_counter.sv ***
`timescale 1ns/1ns
// Loadable down counter that times wake intervals
module wake_counter
  import standby_pkg::*;
#(
  parameter int W = CNT_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic run,
  output logic done
);
  logic [W-1:0] cnt_r;

  // Count down while run; done pulses high once it reaches zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (load) begin
      cnt_r <= load_val;
    end else if (run && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      done <= 1'b0;
    end else begin
      done <= run && !load && (cnt_r == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// *** standby_clock_controller.sv ***
`timescale 1ns/1ns
// Standby controller: idle and deep-stop modes with settling wait
module standby_clock_controller
  import standby_pkg::*;
#(
  parameter int HOLD_CYC = STOP_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic idle_instr,
  input wire logic stop_instr,
  input wire logic irq_pending,
  input wire logic global_irq_enable,
  input wire logic osc_started,
  input wire logic xtal_sel,
  input wire logic slow_osc_stoppable,
  input wire logic slow_osc_halt_bit,
  input wire logic wdt_on_slow_clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_wr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic cpu_clk_en,
  output logic sys_osc_en,
  output logic slow_osc_en,
  output logic wdt_run,
  output logic periph_clk_en,
  output logic hold_io,
  output logic resume_vector,
  output logic resume_next
);
  sb_state_t state_r;
  logic [1:0] settle_sel_r;
  logic irq_s1_r;
  logic irq_s2_r;
  logic osc_s1_r;
  logic osc_s2_r;
  logic ctr_load;
  logic [CNT_W-1:0] ctr_val;
  logic ctr_run;
  logic ctr_done;
  logic sel_hit;
  logic [CNT_W-1:0] settle_cycles;

  // Wake sources come from other clocks or pins: two-stage synchronisers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
      osc_s1_r <= 1'b0;
      osc_s2_r <= 1'b0;
    end else begin
      irq_s1_r <= irq_pending;
      irq_s2_r <= irq_s1_r;
      osc_s1_r <= osc_started;
      osc_s2_r <= osc_s1_r;
    end
  end

  assign sel_hit = (mem_addr == OSC_SETTLE_SELECT_ADDR);

  // Settling select register; undefined by spec, reset to a known value here
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      settle_sel_r <= SETTLE_SEL_RST;
    end else if (mem_wr && sel_hit) begin
      settle_sel_r <= mem_wdata[SETTLE_SEL_HI_POS:SETTLE_SEL_LO_POS];
    end
  end

  // Read data: upper bits read zero
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mem_rdata <= 8'h00;
    end else if (mem_rd && sel_hit) begin
      mem_rdata <= {6'h00, settle_sel_r};
    end else begin
      mem_rdata <= 8'h00;
    end
  end

  // Settling length from the select field
  always_comb begin
    case (settle_sel_r)
      2'h0: settle_cycles = CNT_W'(1 << SETTLE_EXP_0);
      2'h1: settle_cycles = CNT_W'(1 << SETTLE_EXP_1);
      2'h2: settle_cycles = CNT_W'(1 << SETTLE_EXP_2);
      default: settle_cycles = CNT_W'(1 << SETTLE_EXP_3);
    endcase
  end

  // Counter load on entering each timed state
  always_comb begin
    ctr_load = 1'b0;
    ctr_val = '0;
    case (state_r)
      ST_RUN: begin
        // Stop with a wake already pending skips the halt but still holds
        if (stop_instr && irq_s2_r) begin
          ctr_load = 1'b1;
          ctr_val = CNT_W'(HOLD_CYC);
        end
      end
      ST_OSCWAIT: begin
        if (osc_s2_r) begin
          ctr_load = 1'b1;
          // Crystal waits for settling; others go straight to the hold
          ctr_val = xtal_sel ? settle_cycles : CNT_W'(HOLD_CYC);
        end
      end
      ST_SETTLE: begin
        if (ctr_done) begin
          ctr_load = 1'b1;
          ctr_val = CNT_W'(HOLD_CYC);
        end
      end
      ST_IDLE: begin
        if (irq_s2_r) begin
          ctr_load = 1'b1;
          ctr_val = global_irq_enable ? CNT_W'(IDLE_RESUME_VEC - 2)
                                      : CNT_W'(IDLE_RESUME_NOVEC - 2);
        end
      end
      default: begin
        ctr_load = 1'b0;
        ctr_val = '0;
      end
    endcase
  end

  assign ctr_run = (state_r == ST_SETTLE) || (state_r == ST_HOLD) || (state_r == ST_RESUME);

  wake_counter #(.W(CNT_W)) u_ctr (
    .mclk(mclk),
    .resetn(resetn),
    .load(ctr_load),
    .load_val(ctr_val),
    .run(ctr_run),
    .done(ctr_done)
  );

  // Mode sequencer; reset leaves any mode at once (async reset)
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_RUN; // Reset wait belongs to the option byte, not the select field
    end else begin
      case (state_r)
        ST_RUN: begin
          // Instructions only taken here, so none lands mid-wake
          if (stop_instr) begin
            state_r <= irq_s2_r ? ST_HOLD : ST_STOP;
          end else if (idle_instr) begin
            state_r <= irq_s2_r ? ST_RUN : ST_IDLE;
          end
        end
        ST_IDLE: if (irq_s2_r) state_r <= ST_RESUME;
        ST_STOP: if (irq_s2_r) state_r <= ST_OSCWAIT;
        ST_OSCWAIT: begin
          if (osc_s2_r) state_r <= xtal_sel ? ST_SETTLE : ST_HOLD;
        end
        ST_SETTLE: if (ctr_done) state_r <= ST_HOLD;
        ST_HOLD: if (ctr_done) state_r <= ST_RUN;
        ST_RESUME: if (ctr_done) state_r <= ST_RUN;
        default: state_r <= ST_RUN;
      endcase
    end
  end

  // Clock gates are registered so the CPU clock enable never glitches
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cpu_clk_en <= 1'b1;
      sys_osc_en <= 1'b1;
      periph_clk_en <= 1'b1;
      hold_io <= 1'b0;
    end else begin
      cpu_clk_en <= (state_r == ST_RUN) && !(idle_instr && !irq_s2_r)
                    && !stop_instr;
      sys_osc_en <= !(state_r == ST_STOP) && !(state_r == ST_RUN && stop_instr && !irq_s2_r);
      periph_clk_en <= (state_r != ST_STOP) && (state_r != ST_OSCWAIT);
      hold_io <= (state_r != ST_RUN);
    end
  end

  // Slow oscillator: only software halt may stop it, never standby
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      slow_osc_en <= 1'b1;
      wdt_run <= 1'b1;
    end else begin
      slow_osc_en <= !(slow_osc_stoppable && slow_osc_halt_bit);
      wdt_run <= !(wdt_on_slow_clk && state_r == ST_STOP);
    end
  end

  // Resume kind flags stand one cycle at return to run from idle (ST_RESUME only)
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      resume_vector <= 1'b0;
      resume_next <= 1'b0;
    end else begin
      resume_vector <= (state_r == ST_RESUME) && ctr_done && global_irq_enable;
      resume_next <= (state_r == ST_RESUME) && ctr_done && !global_irq_enable;
    end
  end

  property p_idle_gates;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_RUN && idle_instr && !irq_s2_r && !stop_instr) |=> !cpu_clk_en && sys_osc_en;
  endproperty
  a_idle_gates: assert property (p_idle_gates) else $error("idle did not gate cpu clock");

  property p_stop_osc;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_STOP) |=> !sys_osc_en || $past(irq_s2_r);
  endproperty
  a_stop_osc: assert property (p_stop_osc) else $error("oscillator ran in deep-stop");

  property p_stop_wake;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_STOP && irq_s2_r) |=> state_r == ST_OSCWAIT;
  endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("interrupt did not wake");

  property p_slow_kept;
    @(posedge mclk) disable iff (!resetn)
      !slow_osc_stoppable |=> slow_osc_en;
  endproperty
  a_slow_kept: assert property (p_slow_kept) else $error("slow oscillator stopped");

  property p_wdt_stop;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_STOP && wdt_on_slow_clk) |=> !wdt_run;
  endproperty
  a_wdt_stop: assert property (p_wdt_stop) else $error("watchdog ran in deep-stop");

  property p_no_xtal_wait;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_OSCWAIT && osc_s2_r && !xtal_sel) |=> state_r == ST_HOLD;
  endproperty
  a_no_xtal_wait: assert property (p_no_xtal_wait) else $error("wait applied without crystal");

  property p_wait_osc;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_OSCWAIT && !osc_s2_r) |=> state_r == ST_OSCWAIT;
  endproperty
  a_wait_osc: assert property (p_wait_osc) else $error("settle began before oscillation");

  property p_idle_resume;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_IDLE && irq_s2_r && !global_irq_enable) |-> ##[3:5] cpu_clk_en;
  endproperty
  a_idle_resume: assert property (p_idle_resume) else $error("idle resume late");

  property p_gated_wake;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_SETTLE) |=> !cpu_clk_en;
  endproperty
  a_gated_wake: assert property (p_gated_wake) else $error("cpu clock ran during settle");

  property p_ignore_instr;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_HOLD && !ctr_done) |=> state_r == ST_HOLD;
  endproperty
  a_ignore_instr: assert property (p_ignore_instr) else $error("hold cut short");

  property p_pending_stop;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_RUN && stop_instr && irq_s2_r) |=> state_r == ST_HOLD && sys_osc_en;
  endproperty
  a_pending_stop: assert property (p_pending_stop) else $error("pending stop halted");

  property p_vec_resume;
    @(posedge mclk) disable iff (!resetn)
      (state_r == ST_IDLE && irq_s2_r && global_irq_enable) |-> ##[11:13] cpu_clk_en;
  endproperty
  a_vec_resume: assert property (p_vec_resume) else $error("vectored resume late");

  property p_io_held;
    @(posedge mclk) disable iff (!resetn)
      (state_r != ST_RUN) |=> hold_io;
  endproperty
  a_io_held: assert property (p_io_held) else $error("port state not held");

  c_idle: cover property (@(posedge mclk) state_r == ST_IDLE ##1 state_r == ST_RESUME);
  c_settle: cover property (@(posedge mclk) state_r == ST_SETTLE ##1 state_r == ST_HOLD);
  c_hold_done: cover property (@(posedge mclk) state_r == ST_HOLD ##1 state_r == ST_RUN);
  c_pending_stop: cover property (@(posedge mclk) state_r == ST_RUN ##1 state_r == ST_HOLD);
endmodule

// *** osc_partner.sv ***
// Behavioural system oscillator model that reports oscillation after a start-up delay
`timescale 1ns/1ns
module osc_partner #(
  parameter int START_DLY = 7
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic sys_osc_en,
  output logic osc_started
);
  int cnt;
  // Start-up gap after enable; the settling wait must not include it
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt <= START_DLY;
    end else if (!sys_osc_en) begin
      cnt <= 0;
    end else if (cnt < START_DLY) begin
      cnt <= cnt + 1;
    end
  end
  // A halted oscillator stops reporting at once, so a stale flag cannot end the gap early
  assign osc_started = sys_osc_en && (cnt >= START_DLY);
endmodule

// *** standby_clock_controller_test.sv ***
// Self-checking bench for the standby clock controller
`timescale 1ns/1ns
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module standby_clock_controller_test;
  import standby_pkg::*;
  localparam int HOLD = 20;
  localparam int START = 7;
  logic mclk;
  logic resetn = 1'b0;
  logic idle_instr = 1'b0;
  logic stop_instr = 1'b0;
  logic irq_pending = 1'b0;
  logic global_irq_enable = 1'b0;
  logic osc_started;
  logic xtal_sel = 1'b0;
  logic slow_osc_stoppable = 1'b0;
  logic slow_osc_halt_bit = 1'b0;
  logic wdt_on_slow_clk = 1'b1;
  logic [15:0] mem_addr = 16'h0000;
  logic mem_wr = 1'b0;
  logic mem_rd = 1'b0;
  logic [7:0] mem_wdata = 8'h00;
  logic [7:0] mem_rdata, rdv;
  logic cpu_clk_en, sys_osc_en, slow_osc_en, wdt_run, periph_clk_en, hold_io;
  logic resume_vector, resume_next, sv, sn;
  int fail_count = 0;
  int n_tests = 0;
  int cyc;
  int exps[3] = '{SETTLE_EXP_0, SETTLE_EXP_1, SETTLE_EXP_2};

  standby_clock_controller #(.HOLD_CYC(HOLD)) standby_clock_controller_i (
    .mclk(mclk), .resetn(resetn), .idle_instr(idle_instr), .stop_instr(stop_instr),
    .irq_pending(irq_pending), .global_irq_enable(global_irq_enable),
    .osc_started(osc_started), .xtal_sel(xtal_sel), .slow_osc_stoppable(slow_osc_stoppable),
    .slow_osc_halt_bit(slow_osc_halt_bit), .wdt_on_slow_clk(wdt_on_slow_clk),
    .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .cpu_clk_en(cpu_clk_en), .sys_osc_en(sys_osc_en),
    .slow_osc_en(slow_osc_en), .wdt_run(wdt_run), .periph_clk_en(periph_clk_en),
    .hold_io(hold_io), .resume_vector(resume_vector), .resume_next(resume_next));
  osc_partner #(.START_DLY(START)) osc_partner_i (
    .mclk(mclk), .resetn(resetn), .sys_osc_en(sys_osc_en), .osc_started(osc_started));

  // Clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Inputs move on the falling edge only
  task automatic tick(int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    mem_addr = a; mem_wdata = d; mem_wr = 1'b1; tick(1); mem_wr = 1'b0;
  endtask
  // Read data is registered, valid for the cycle after the strobe
  task automatic rd(logic [15:0] a, output logic [7:0] d);
    mem_addr = a; mem_rd = 1'b1; tick(1); mem_rd = 1'b0; d = mem_rdata; tick(1);
  endtask
  task automatic instr(logic stp);
    if (stp) stop_instr = 1'b1; else idle_instr = 1'b1;
    tick(1); stop_instr = 1'b0; idle_instr = 1'b0; tick(1);
  endtask
  // Raise the wake request and count cycles until the CPU clock is back
  task automatic wake(logic gie);
    global_irq_enable = gie; irq_pending = 1'b1; cyc = 0; sv = 1'b0; sn = 1'b0;
    while (cpu_clk_en !== 1'b1 && cyc < 40000) begin
      tick(1); cyc++; sv |= resume_vector; sn |= resume_next;
    end
    // Let the synchroniser drain so the next entry is not taken as pending
    irq_pending = 1'b0; tick(3); sv |= resume_vector; sn |= resume_next;
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Longest run is about 33k cycles of settling; the limit leaves ample margin
  initial begin
    #900000;
    fail_count++;
    results();
  end

  initial begin
    tick(20); resetn = 1'b1; tick(1);
    `CHK({cpu_clk_en, sys_osc_en, periph_clk_en, hold_io}, 4'b1110)
    wr(OSC_SETTLE_SELECT_ADDR, 8'hfe); rd(OSC_SETTLE_SELECT_ADDR, rdv);
    `CHK(rdv, 8'h02)
    rd(16'hfff5, rdv); `CHK(rdv, 8'h00)
    wr(OSC_SETTLE_SELECT_ADDR, 8'h03); rd(OSC_SETTLE_SELECT_ADDR, rdv);
    `CHK(rdv, 8'h03)
    slow_osc_halt_bit = 1'b1; tick(2); `CHK(slow_osc_en, 1'b1)
    slow_osc_stoppable = 1'b1; tick(2); `CHK(slow_osc_en, 1'b0)
    slow_osc_halt_bit = 1'b0; tick(2); `CHK(slow_osc_en, 1'b1)
    $display("test registers done");
    // Idle, vectored then not; a stop request while idle is ignored
    for (int g = 1; g >= 0; g--) begin
      instr(1'b0);
      `CHK({cpu_clk_en, sys_osc_en, periph_clk_en, hold_io}, 4'b0111)
      `CHK({slow_osc_en, wdt_run}, 2'b11)
      instr(1'b1); `CHK(sys_osc_en, 1'b1)
      wake(g[0]);
      `CHK({sv, sn}, {g[0], ~g[0]})
      `CHK(cyc >= (g ? 11 : 3) && cyc <= (g ? 17 : 9), 1'b1)
    end
    $display("test idle done");
    // Pending request at entry: idle never starts, stop skips the settling wait
    irq_pending = 1'b1; tick(3); instr(1'b0); tick(1);
    `CHK(cpu_clk_en, 1'b1)
    xtal_sel = 1'b1; instr(1'b1); wake(1'b0);
    `CHK(cyc <= HOLD + 8, 1'b1)
    instr(1'b0); resetn = 1'b0; tick(1);
    `CHK({cpu_clk_en, hold_io}, 2'b10)
    resetn = 1'b1; tick(2);
    $display("test pending and reset done");
    // Deep stop with internal clock: oscillator start-up then hold interval, no settling wait
    xtal_sel = 1'b0; instr(1'b1); // bench keeps peripherals and converter idle
    `CHK({cpu_clk_en, sys_osc_en, periph_clk_en, hold_io}, 4'b0001)
    `CHK({slow_osc_en, wdt_run}, 2'b10)
    instr(1'b0); `CHK(cpu_clk_en, 1'b0)
    wake(1'b1);
    `CHK(cyc >= HOLD && cyc <= HOLD + START + 12, 1'b1)
    // Crystal clock: select field chosen before stop, counted after start-up
    xtal_sel = 1'b1;
    for (int s = 0; s < 3; s++) begin
      wr(OSC_SETTLE_SELECT_ADDR, 8'(s)); instr(1'b1); wake(1'b1);
      `CHK(cyc >= (1 << exps[s]) + HOLD + START, 1'b1)
      `CHK(cyc <= (1 << exps[s]) + HOLD + START + 16, 1'b1)
    end
    $display("test deep stop done");
    results();
  end
endmodule
